// ===== logic/rmcd_pkg.sv
// constants, register map and state types for the config command decoder
package rmcd_pkg;

    // register addresses (first byte of each frame)
    localparam logic [7:0] ADDR_INIT      = 8'h01;
    localparam logic [7:0] ADDR_ACTIVE    = 8'h02;
    localparam logic [7:0] ADDR_FREQ      = 8'h10;
    localparam logic [7:0] ADDR_AMP       = 8'h12;
    localparam logic [7:0] ADDR_ATTEN     = 8'h13;
    localparam logic [7:0] ADDR_ROUTE     = 8'h14;
    localparam logic [7:0] ADDR_OUTFILT   = 8'h15;
    localparam logic [7:0] ADDR_OSCFILT   = 8'h16;
    localparam logic [7:0] ADDR_OSCPASS   = 8'h17;
    localparam logic [7:0] ADDR_OFFDAC    = 8'h1a;
    localparam logic [7:0] ADDR_BIASDAC   = 8'h1b;
    localparam logic [7:0] ADDR_STORE     = 8'h1d;
    localparam logic [7:0] ADDR_NVM       = 8'h1f;

    // data byte counts per register
    localparam logic [2:0] LEN_NONE   = 3'h0;
    localparam logic [2:0] LEN_BYTE   = 3'h1;
    localparam logic [2:0] LEN_ATTEN  = 3'h2;
    localparam logic [2:0] LEN_TRIPLE = 3'h3;
    localparam logic [2:0] LEN_FREQ   = 3'h5;

    // field positions inside the assembled frame word
    localparam int MODE_BIT    = 0;
    localparam int ATT_SEL_LSB = 8;
    localparam int ATT_VAL_MSB = 4;
    localparam int FILT_MSB    = 3;
    localparam int DAC_MSB     = 13;
    localparam int DAC_CH_BIT  = 16;
    localparam int NVM_ADR_LSB = 8;

    // init_control mode value that reloads the stored defaults
    localparam logic INIT_RELOAD = 1'h0;

    typedef enum logic [2:0] {
        S_IDLE    = 3'b001,
        S_COLLECT = 3'b010,
        S_DISCARD = 3'b100
    } rmcd_state_e_t;

    // configuration image held by the device
    typedef struct packed {
        logic            activeLed;
        logic [39:0]     freqWord;
        logic            ampEnable;
        logic [3:0][4:0] atten;
        logic            routeAux;
        logic [3:0]      outFilter;
        logic [3:0]      oscFilter;
        logic            oscPass;
        logic [13:0]     offsetDac;
        logic            offsetChan;
        logic [13:0]     biasDac;
        logic            biasChan;
    } rmcd_cfg_t;

    // all state of the decoder
    typedef struct packed {
        rmcd_state_e_t st;
        logic [7:0]    addr;
        logic [2:0]    cnt;
        logic [31:0]   shiftBuf;
        rmcd_cfg_t     cfg;
        rmcd_cfg_t     dflt;
        logic          accessed;
        logic [15:0]   nvmAddr;
        logic [7:0]    nvmData;
        logic          nvmWrite;
        logic          softReset;
        logic          storeDone;
        logic          frameDrop;
    } rmcd_state_t;

    // power-on configuration and decoder state
    localparam rmcd_cfg_t CFG_RESET = '0;
    localparam rmcd_state_t STATE_RESET = '{
        st: S_IDLE, addr: 8'h00, cnt: 3'h0, shiftBuf: 32'h00000000,
        cfg: CFG_RESET, dflt: CFG_RESET, accessed: 1'h0,
        nvmAddr: 16'h0000, nvmData: 8'h00, nvmWrite: 1'h0,
        softReset: 1'h0, storeDone: 1'h0, frameDrop: 1'h0};

    // data byte count for an address byte, zero when unmapped
    function automatic logic [2:0] frameLen(input logic [7:0] a);
        unique case (a)
            ADDR_FREQ:                          return LEN_FREQ;
            ADDR_ATTEN:                         return LEN_ATTEN;
            ADDR_OFFDAC, ADDR_BIASDAC, ADDR_NVM: return LEN_TRIPLE;
            ADDR_INIT, ADDR_ACTIVE, ADDR_AMP, ADDR_ROUTE, ADDR_OUTFILT,
            ADDR_OSCFILT, ADDR_OSCPASS, ADDR_STORE:
                                                return LEN_BYTE;
            default:                            return LEN_NONE;
        endcase
    endfunction

endpackage

// ===== logic/rmcd_decoder.sv
// byte-stream decoder for the write-only configuration registers
// What this block does
// - configure via writes, report via status bits
// - configuration registers have no read-back path
// - address byte first, data bytes MSB first
// - attenuation: selector byte, then setting byte
// - init_control with 0x00 reloads stored defaults
// - init_control with 0x01 resets, keeps settings
// - store command makes current config the default
// - each address has fixed byte count
// - frequency is 40-bit word, LSB one hertz
// - four 5-bit attenuators, selector 0 to 3
// - amplifier bit 0 enables the amplifier
module rmcd_decoder
    import rmcd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        byteValid,
    input  wire logic        frameStart,
    input  wire logic [7:0]  byteData,
    output logic             activeLed,
    output logic [39:0]      freqWord,
    output logic             ampEnable,
    output logic [19:0]      attenSettings,
    output logic             routeAux,
    output logic [3:0]       outFilter,
    output logic [3:0]       oscFilter,
    output logic             oscPass,
    output logic [13:0]      offsetDac,
    output logic             offsetChan,
    output logic [13:0]      biasDac,
    output logic             biasChan,
    output logic             nvmWrite,
    output logic [15:0]      nvmAddr,
    output logic [7:0]       nvmData,
    output logic             softReset,
    output logic             storeDone,
    output logic             frameDrop,
    output logic [3:0]       statusBits
);

    rmcd_state_t s;
    rmcd_state_t n;
    logic [39:0] word;
    logic        lastByte;

    // assembled frame word: earlier bytes are the more significant
    // msb first
    assign word     = {s.shiftBuf, byteData};
    assign lastByte = (s.st == S_COLLECT) &&
                      (s.cnt == frameLen(s.addr) - 3'h1);

    // next-state logic: frame parse and register commit
    always_comb begin
        n           = s;
        n.nvmWrite  = 1'h0;
        n.softReset = 1'h0;
        n.storeDone = 1'h0;
        n.frameDrop = 1'h0;
        if (byteValid && frameStart) begin
            n.addr     = byteData;
            n.cnt      = 3'h0;
            n.shiftBuf = 32'h00000000;
            if (frameLen(byteData) == LEN_NONE) begin
                n.st        = S_DISCARD;
                n.frameDrop = 1'h1;
            end else begin
                n.st = S_COLLECT;
            end
        end else if (byteValid) begin
            unique case (s.st)
                S_COLLECT: begin
                    n.shiftBuf = word[31:0];
                    n.cnt      = s.cnt + 3'h1;
                    if (lastByte) begin
                        n.st       = S_IDLE;
                        n.accessed = 1'h1;
                        unique case (s.addr)
                            ADDR_INIT: begin
                                n.softReset = 1'h1;
                                if (word[MODE_BIT] == INIT_RELOAD) begin
                                    n.cfg = s.dflt;
                                end
                            end
                            ADDR_ACTIVE: begin
                                n.cfg.activeLed = word[MODE_BIT];
                            end
                            ADDR_FREQ: begin
                                n.cfg.freqWord = word;
                            end
                            ADDR_AMP: begin
                                n.cfg.ampEnable = word[MODE_BIT];
                            end
                            ADDR_ATTEN: begin
                                n.cfg.atten[word[ATT_SEL_LSB+:2]] =
                                    word[ATT_VAL_MSB:0];
                            end
                            ADDR_ROUTE: begin
                                n.cfg.routeAux = word[MODE_BIT];
                            end
                            ADDR_OUTFILT: begin
                                n.cfg.outFilter = word[FILT_MSB:0];
                            end
                            ADDR_OSCFILT: begin
                                n.cfg.oscFilter = word[FILT_MSB:0];
                            end
                            ADDR_OSCPASS: begin
                                n.cfg.oscPass = word[MODE_BIT];
                            end
                            ADDR_OFFDAC: begin
                                n.cfg.offsetDac  = word[DAC_MSB:0];
                                n.cfg.offsetChan = word[DAC_CH_BIT];
                            end
                            ADDR_BIASDAC: begin
                                n.cfg.biasDac  = word[DAC_MSB:0];
                                n.cfg.biasChan = word[DAC_CH_BIT];
                            end
                            ADDR_STORE: begin
                                n.dflt      = s.cfg;
                                n.storeDone = 1'h1;
                            end
                            ADDR_NVM: begin
                                n.nvmAddr  = word[NVM_ADR_LSB+:16];
                                n.nvmData  = word[7:0];
                                n.nvmWrite = 1'h1;
                            end
                            default: begin
                                n.st = S_IDLE;
                            end
                        endcase
                    end
                end
                S_IDLE, S_DISCARD: begin
                    n.st = s.st;
                end
            endcase
        end
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= STATE_RESET;
        end else if (ce) begin
            s <= n;
        end
    end

    // outputs straight from the state register
    // write-only, no read path
    assign activeLed     = s.cfg.activeLed;
    assign freqWord      = s.cfg.freqWord;
    assign ampEnable     = s.cfg.ampEnable;
    assign attenSettings = s.cfg.atten;
    assign routeAux      = s.cfg.routeAux;
    assign outFilter     = s.cfg.outFilter;
    assign oscFilter     = s.cfg.oscFilter;
    assign oscPass       = s.cfg.oscPass;
    assign offsetDac     = s.cfg.offsetDac;
    assign offsetChan    = s.cfg.offsetChan;
    assign biasDac       = s.cfg.biasDac;
    assign biasChan      = s.cfg.biasChan;
    assign nvmWrite      = s.nvmWrite;
    assign nvmAddr       = s.nvmAddr;
    assign nvmData       = s.nvmData;
    assign softReset     = s.softReset;
    assign storeDone     = s.storeDone;
    assign frameDrop     = s.frameDrop;
    assign statusBits    = {s.cfg.ampEnable, s.cfg.routeAux,
                            s.cfg.oscPass, s.accessed};

    // helper terms for the checks below
    logic commit;
    assign commit = ce && byteValid && !frameStart && lastByte;

    sequence initCommit(logic mode);
        commit && s.addr == ADDR_INIT && word[MODE_BIT] == mode;
    endsequence

    sequence storeCommit;
        commit && s.addr == ADDR_STORE;
    endsequence

    sequence attenCommit;
        commit && s.addr == ADDR_ATTEN;
    endsequence

    sequence nvmCommit;
        commit && s.addr == ADDR_NVM;
    endsequence

    // a data byte that arrives while no frame is being collected
    sequence strayByte;
        ce && byteValid && !frameStart && s.st != S_COLLECT;
    endsequence

    unknown_addr_drop_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && byteValid && frameStart && frameLen(byteData) == LEN_NONE
        |=> frameDrop && s.st == S_DISCARD)
        else $error("unknown address not dropped");

    freq_whole_word_a: assert property (
        @(posedge clk) disable iff (!rstn)
        $changed(freqWord) |-> $past(s.cnt) == 3'h4 &&
        $past(s.addr) == ADDR_FREQ && $past(commit) ||
        $past(s.addr) == ADDR_INIT && $past(commit))
        else $error("frequency changed without a full frame");

    freq_load_a: assert property (
        @(posedge clk) disable iff (!rstn)
        commit && s.addr == ADDR_FREQ |=> freqWord == $past(word))
        else $error("frequency word not loaded");

    amp_enable_a: assert property (
        @(posedge clk) disable iff (!rstn)
        commit && s.addr == ADDR_AMP |=> ampEnable == $past(byteData[0]))
        else $error("amplifier enable wrong");

    atten_fourth_a: assert property (
        @(posedge clk) disable iff (!rstn)
        commit && s.addr == ADDR_ATTEN && s.shiftBuf[1:0] == 2'h3
        |=> attenSettings[19:15] == $past(byteData[4:0]))
        else $error("fourth attenuator not loaded");

    init_reload_a: assert property (
        @(posedge clk) disable iff (!rstn)
        initCommit(1'h0) |=> softReset && s.cfg == $past(s.dflt))
        else $error("defaults not reloaded");

    init_keep_a: assert property (
        @(posedge clk) disable iff (!rstn)
        initCommit(1'h1) |=> softReset && s.cfg == $past(s.cfg))
        else $error("settings lost on keep reset");

    store_default_a: assert property (
        @(posedge clk) disable iff (!rstn)
        storeCommit |=> storeDone && s.dflt == $past(s.cfg))
        else $error("default not stored");

    // expected count spelled out per address, apart from frameLen
    byte_count_a: assert property (
        @(posedge clk) disable iff (!rstn)
        commit |-> s.cnt + 3'h1 == (s.addr == ADDR_FREQ    ? LEN_FREQ   :
                                    s.addr == ADDR_ATTEN   ? LEN_ATTEN  :
                                    s.addr == ADDR_OFFDAC  ||
                                    s.addr == ADDR_BIASDAC ||
                                    s.addr == ADDR_NVM     ? LEN_TRIPLE :
                                                             LEN_BYTE))
        else $error("commit at wrong byte count");

    atten_select_a: assert property (
        @(posedge clk) disable iff (!rstn)
        attenCommit |=> s.cfg.atten[$past(s.shiftBuf[1:0])] ==
                        $past(byteData[4:0]))
        else $error("selected attenuator not loaded");

    frame_abort_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && byteValid && frameStart |=> s.cfg == $past(s.cfg))
        else $error("settings changed on an address byte");

    stray_byte_a: assert property (
        @(posedge clk) disable iff (!rstn)
        strayByte |=> s.cfg == $past(s.cfg) && s.st == $past(s.st))
        else $error("byte outside a frame was taken");

    dac_load_a: assert property (
        @(posedge clk) disable iff (!rstn)
        commit && s.addr == ADDR_OFFDAC |=> {offsetChan, offsetDac} ==
            $past({s.shiftBuf[8], s.shiftBuf[5:0], byteData}))
        else $error("offset dac not loaded");

    filter_load_a: assert property (
        @(posedge clk) disable iff (!rstn)
        commit && s.addr == ADDR_OUTFILT |=>
            outFilter == $past(byteData[3:0]))
        else $error("output filter not loaded");

    nvm_write_a: assert property (
        @(posedge clk) disable iff (!rstn)
        nvmCommit |=> nvmWrite && nvmAddr == $past(s.shiftBuf[15:0]) &&
                      nvmData == $past(byteData))
        else $error("user memory write not issued");

    // command pulses never run into a second enabled cycle
    pulse_single_a: assert property (
        @(posedge clk) disable iff (!rstn)
        ce && (nvmWrite || softReset || storeDone) |=>
            !nvmWrite && !softReset && !storeDone)
        else $error("command pulse longer than one cycle");

    // clock enable low freezes every bit of state
    freeze_hold_a: assert property (
        @(posedge clk) disable iff (!rstn)
        !ce |=> $stable(s))
        else $error("state moved while frozen");

endmodule

// ===== tb/rmcd_host_model.sv
// host side byte source that sends register write frames
module rmcd_host_model (
    input  wire logic       clk,
    output logic            byteValid,
    output logic            frameStart,
    output logic [7:0]      byteData
);
    timeunit 1ns;
    timeprecision 100ps;

    // lines idle at time zero, data pattern meaningless outside frames
    initial begin
        byteValid  = 1'h0;
        frameStart = 1'h0;
        byteData   = 8'ha5;
    end

    // one frame after an idle cycle, gap idle cycles between bytes
    // whole frame, in order
    task automatic send(input logic [7:0] q[$], input int gap);
        @(posedge clk);
        #1;
        foreach (q[i]) begin
            byteValid  = 1'h1;
            frameStart = (i == 0);
            byteData   = q[i];
            @(posedge clk);
            #1;
            // released byte lane shows a toggling pattern, not old data
            if (gap > 0 || i == q.size() - 1) begin
                byteValid  = 1'h0;
                frameStart = 1'h0;
                byteData   = ~q[i];
            end
            repeat (gap) begin
                @(posedge clk);
                #1;
                byteData = ~byteData;
            end
        end
    endtask
endmodule

// ===== tb/test_rmcd_decoder.sv
// self-checking bench for the configuration command decoder
module test_rmcd_decoder import rmcd_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk;
    logic        rstn;
    logic        ce;
    logic        byteValid;
    logic        frameStart;
    logic [7:0]  byteData;
    logic        activeLed;
    logic [39:0] freqWord;
    logic        ampEnable;
    logic [19:0] attenSettings;
    logic        routeAux;
    logic [3:0]  outFilter;
    logic [3:0]  oscFilter;
    logic        oscPass;
    logic [13:0] offsetDac;
    logic        offsetChan;
    logic [13:0] biasDac;
    logic        biasChan;
    logic        nvmWrite;
    logic [15:0] nvmAddr;
    logic [7:0]  nvmData;
    logic        softReset;
    logic        storeDone;
    logic        frameDrop;
    logic [3:0]  statusBits;
    int          nMismatch = 0;
    int          checkCount = 0;
    int          i;

    rmcd_host_model host_i (.clk, .byteValid, .frameStart, .byteData);

    rmcd_decoder rmcd_decoder_i (
        .clk, .rstn, .ce, .byteValid, .frameStart, .byteData,
        .activeLed, .freqWord, .ampEnable, .attenSettings, .routeAux,
        .outFilter, .oscFilter, .oscPass, .offsetDac, .offsetChan,
        .biasDac, .biasChan, .nvmWrite, .nvmAddr, .nvmData,
        .softReset, .storeDone, .frameDrop, .statusBits
    );

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // compare one value, count it, report a mismatch
    task automatic chk(input string nm, input logic [39:0] exp,
                       input logic [39:0] got);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // counts, verdict and end of run
    task automatic closeOut();
        $display("checks %0d mismatches %0d", checkCount, nMismatch);
        if (nMismatch == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // test run is about 130 cycles, so this limit is generous
    initial begin
        repeat (4000) @(posedge clk);
        nMismatch++;
        $display("[ERR] watchdog expected done seen hang");
        closeOut();
    end

    // main sequence of frames and expected results
    initial begin
        rstn = 1'h0;
        ce   = 1'h1;
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'h1;
        chk("statusBits", 4'h0, statusBits);
        host_i.send('{ADDR_AMP, 8'h01}, 0);
        chk("ampEnable", 1'h1, ampEnable);
        chk("statusBits", 4'h9, statusBits);
        host_i.send('{ADDR_AMP, 8'hfe}, 1);
        chk("ampEnable", 1'h0, ampEnable);
        host_i.send('{ADDR_FREQ, 8'h12, 8'h34, 8'h56,
                      8'h78, 8'h9a}, 2);
        chk("freqWord", 40'h123456789a, freqWord);
        // partial frame cut off by a new address byte
        host_i.send('{ADDR_FREQ, 8'haa, 8'hbb}, 0);
        host_i.send('{ADDR_ROUTE, 8'h01}, 0);
        chk("freqWord", 40'h123456789a, freqWord);
        chk("routeAux", 1'h1, routeAux);
        for (i = 0; i < 4; i++) begin
            host_i.send('{ADDR_ATTEN, 8'hfc | i[7:0],
                          8'he0 | (8'h11 + i[7:0])}, 0);
        end
        chk("atten", {5'h14, 5'h13, 5'h12, 5'h11}, attenSettings);
        host_i.send('{ADDR_OUTFILT, 8'hf9}, 0);
        chk("outFilter", 4'h9, outFilter);
        host_i.send('{ADDR_OSCFILT, 8'h03}, 0);
        chk("oscFilter", 4'h3, oscFilter);
        host_i.send('{ADDR_OSCPASS, 8'h01}, 0);
        chk("statusBits", 4'h7, statusBits);
        host_i.send('{ADDR_ACTIVE, 8'h01}, 0);
        chk("activeLed", 1'h1, activeLed);
        host_i.send('{ADDR_OFFDAC, 8'h01, 8'hff, 8'hff}, 0);
        chk("offsetDac", {1'h1, 14'h3fff}, {offsetChan, offsetDac});
        host_i.send('{ADDR_BIASDAC, 8'hfe, 8'hd2, 8'h34}, 1);
        chk("biasDac", {1'h0, 14'h1234}, {biasChan, biasDac});
        host_i.send('{ADDR_NVM, 8'h1f, 8'h00, 8'h22}, 0);
        chk("nvm", 25'h11f0022, {nvmWrite, nvmAddr, nvmData});
        @(posedge clk);
        #1;
        chk("nvmWrite", 1'h0, nvmWrite);
        // bytes past the register's count are dropped
        host_i.send('{ADDR_AMP, 8'h00, 8'h01}, 0);
        chk("ampEnable", 1'h0, ampEnable);
        host_i.send('{8'h11}, 0);
        chk("frameDrop", 1'h1, frameDrop);
        // bytes after an unmapped address are swallowed
        host_i.send('{8'h11, ADDR_AMP, 8'h01}, 0);
        chk("ampEnable", 1'h0, ampEnable);
        host_i.send('{ADDR_STORE, 8'h00}, 0);
        chk("storeDone", 1'h1, storeDone);
        host_i.send('{ADDR_AMP, 8'h01}, 0);
        host_i.send('{ADDR_FREQ, 8'h00, 8'h00, 8'h00,
                      8'h00, 8'h01}, 0);
        host_i.send('{ADDR_INIT, 8'h01}, 0);
        chk("softReset", 1'h1, softReset);
        chk("freqAmp", {1'h1, 40'h1}, {ampEnable, freqWord});
        host_i.send('{ADDR_INIT, 8'h00}, 0);
        chk("softReset", 1'h1, softReset);
        chk("freqAmp", {1'h0, 40'h123456789a},
            {ampEnable, freqWord});
        chk("routeAux", 1'h1, routeAux);
        // frozen decoder takes no bytes
        ce = 1'h0;
        host_i.send('{ADDR_AMP, 8'h01}, 0);
        ce = 1'h1;
        chk("ampEnable", 1'h0, ampEnable);
        closeOut();
    end
endmodule
